// *** eeprom_link_pkg.sv ***
/*
 Shared constants for the three-wire serial EEPROM port: field widths,
 opcodes and timing counts. Assumes a 100 MHz core clock on both ends.
*/
`default_nettype none

package eeprom_link_pkg;

   // geometry
   localparam int DEF_ADDR_W = 6;
   localparam int DEF_DATA_W = 8;

   // instruction opcodes, sent after the start bit
   localparam logic [1:0] OP_EXT   = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam int         OP_BITS  = 2;

   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PROGRAM_CYCLE_TIME_NS = 2000;
   localparam int PROGRAM_CYCLES =
      (PROGRAM_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DUMMY_DELAY_NS = 50;
   localparam int DUMMY_DELAY_CYCLES =
      (DUMMY_DELAY_NS / CLK_PERIOD_NS < 1) ? 1
                                           : DUMMY_DELAY_NS / CLK_PERIOD_NS;
   localparam int LINK_HALF_PERIOD_NS = 40;
   localparam int LINK_HALF_CYCLES =
      (LINK_HALF_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1
                                     : LINK_HALF_PERIOD_NS / CLK_PERIOD_NS;

   // host waits this many half periods after raising select before polling
   localparam int STATUS_SETTLE_TICKS = 3;
   // half periods of deselect between two instructions
   localparam int GAP_TICKS = 2;

   // values after reset
   localparam logic RESET_SELECT = 1'b0;
   localparam logic RESET_CLOCK  = 1'b0;
   localparam logic RESET_LINE   = 1'b1;

endpackage

`default_nettype wire

// *** eeprom_link_if.sv ***
/*
 Link between host and EEPROM port: select, serial clock and data.
 Assumes a pull-up on the data wire; with SHARED_IO set, data in and
 data out are one wire and the level is the wired AND of both drivers.
*/
`timescale 1ns/1ps
`default_nettype none

interface eeprom_link_if #(
   parameter bit SHARED_IO = 1'b1
);
   logic chipSelect;
   logic serialClockIn;
   logic hostData;
   logic hostDataOe;
   logic devData;
   logic devDataOe;
   logic lineLevel;
   logic serialDataIn;
   logic hostDataIn;

   // contention resolves low, an undriven wire floats high
   assign lineLevel = (~devDataOe | devData) & (~hostDataOe | hostData);
   assign serialDataIn = SHARED_IO ? lineLevel : (~hostDataOe | hostData);
   assign hostDataIn = SHARED_IO ? lineLevel : (~devDataOe | devData);

   modport device (
      input  chipSelect,
      input  serialClockIn,
      input  serialDataIn,
      output devData,
      output devDataOe
   );

   modport host (
      output chipSelect,
      output serialClockIn,
      output hostData,
      output hostDataOe,
      input  hostDataIn
   );
endinterface

`default_nettype wire

// *** shared_io_eeprom_device.sv ***
/*
 EEPROM end of the three-wire port: instruction decoder, read shifter,
 self-timed programming with status on the data output, and the array.
 Assumes link pins are asynchronous to core_clk and far slower than it.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: select, clock, data in/out; may share one wire
// R2: output high impedance during read command bits
// R3: dummy zero driven after last address edge
// R4: host releases its driver before dummy zero
// R5: contention after address never aborts the read
// R6: self-timed programming; status zero busy, one ready
// R7: status driven whenever select high after programming
// R8: start bit after completion floats status output
// R9: host stops clock after programming instruction
// R10: host clocks once with line high to clear
// R11: select low resets instruction logic
// R12: status clear edge selectable, falling or rising
// R13: read data MSB first after each rising edge
module shared_io_eeprom_device
   import eeprom_link_pkg::*;
#(
   parameter int ADDR_W        = DEF_ADDR_W,
   parameter int DATA_W        = DEF_DATA_W,
   parameter int PROG_CYCLES   = PROGRAM_CYCLES,
   parameter bit CLEAR_ON_FALL = 1'b0
) (
   // clock and reset
   input  wire logic     core_clk,
   input  wire logic     rst_n,
   // link to the host
   eeprom_link_if.device link,
   // state seen by the user
   output logic          progBusy
);

   localparam int DEPTH  = 1 << ADDR_W;
   localparam int CNT_W  = $clog2(ADDR_W + DATA_W + 2);
   localparam int BUSY_W = $clog2(PROG_CYCLES + 1);

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_OPCODE = 3'h1,
      ST_ADDR   = 3'h2,
      ST_READ   = 3'h3,
      ST_WDATA  = 3'h4,
      ST_HOLD   = 3'h5
   } dev_state_t;

   // pin synchronisers: {select, clock, data}
   logic [2:0]        sync1_reg;
   logic [2:0]        sync2_reg;
   logic              skPrev_reg;

   dev_state_t        state_reg,      state_next;
   logic [CNT_W-1:0]  bitCnt_reg,     bitCnt_next;
   logic [1:0]        opcode_reg,     opcode_next;
   logic [ADDR_W-1:0] addr_reg,       addr_next;
   logic [DATA_W-1:0] shift_reg,      shift_next;
   logic              dataOut_reg,    dataOut_next;
   logic              dataOe_reg,     dataOe_next;
   logic              pend_reg,       pend_next;
   logic [ADDR_W-1:0] pendAddr_reg,   pendAddr_next;
   logic [DATA_W-1:0] pendData_reg,   pendData_next;
   logic              busy_reg,       busy_next;
   logic [BUSY_W-1:0] busyCnt_reg,    busyCnt_next;
   logic              armed_reg,      armed_next;

   logic [DATA_W-1:0] mem_reg [DEPTH];
   logic              memWe;

   logic              csHigh;
   logic              din;
   logic              skRise;
   logic              skFall;
   logic              clearEdge;
   logic [ADDR_W-1:0] addrShifted;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg  <= {RESET_SELECT, RESET_CLOCK, RESET_LINE};
         sync2_reg  <= {RESET_SELECT, RESET_CLOCK, RESET_LINE};
         skPrev_reg <= RESET_CLOCK;
      end else begin
         sync1_reg  <= {link.chipSelect, link.serialClockIn,
                        link.serialDataIn};
         sync2_reg  <= sync1_reg;
         skPrev_reg <= sync2_reg[1];
      end
   end

   assign csHigh      = sync2_reg[2];
   assign din         = sync2_reg[0];
   assign skRise      = sync2_reg[1] & ~skPrev_reg;
   assign skFall      = ~sync2_reg[1] & skPrev_reg;
   assign clearEdge   = CLEAR_ON_FALL ? skFall : skRise; // R12
   assign addrShifted = {addr_reg[ADDR_W-2:0], din};

   always_comb begin
      state_next    = state_reg;
      bitCnt_next   = bitCnt_reg;
      opcode_next   = opcode_reg;
      addr_next     = addr_reg;
      shift_next    = shift_reg;
      dataOut_next  = dataOut_reg;
      dataOe_next   = dataOe_reg;
      pend_next     = pend_reg;
      pendAddr_next = pendAddr_reg;
      pendData_next = pendData_reg;
      busy_next     = busy_reg;
      busyCnt_next  = busyCnt_reg;
      armed_next    = armed_reg;
      memWe         = 1'b0;

      // self-timed programming; the array is written at the end
      if (busy_reg) begin // R6
         if (busyCnt_reg == '0) begin
            busy_next = 1'b0;
            memWe     = 1'b1;
         end else begin
            busyCnt_next = busyCnt_reg - 1'b1;
         end
      end

      if (!csHigh) begin
         // deselect drops any partial instruction
         state_next  = ST_IDLE; // R11
         bitCnt_next = '0;
         dataOe_next = 1'b0;
         if (pend_reg) begin
            pend_next    = 1'b0;
            busy_next    = 1'b1;
            busyCnt_next = BUSY_W'(PROG_CYCLES - 1);
            armed_next   = 1'b1;
         end
      end else begin
         case (state_reg)
            ST_IDLE: begin
               // a busy device drives the wire low, no start is seen
               if (skRise && din && !busy_reg) begin // R8
                  state_next  = ST_OPCODE;
                  bitCnt_next = '0;
               end
            end
            ST_OPCODE: begin
               if (skRise) begin
                  opcode_next = {opcode_reg[0], din};
                  bitCnt_next = bitCnt_reg + 1'b1;
                  if (bitCnt_reg == CNT_W'(OP_BITS - 1)) begin
                     state_next  = ST_ADDR;
                     bitCnt_next = '0;
                  end
               end
            end
            ST_ADDR: begin
               dataOe_next = 1'b0; // R2
               if (skRise) begin
                  addr_next   = addrShifted;
                  bitCnt_next = bitCnt_reg + 1'b1;
                  if (bitCnt_reg == CNT_W'(ADDR_W - 1)) begin
                     bitCnt_next = '0;
                     if (opcode_reg == OP_READ) begin
                        dataOut_next = 1'b0; // R3
                        dataOe_next  = 1'b1;
                        shift_next   = mem_reg[addrShifted];
                        state_next   = ST_READ;
                     end else if (opcode_reg == OP_WRITE) begin
                        state_next = ST_WDATA;
                     end else if (opcode_reg == OP_ERASE) begin
                        pend_next     = 1'b1;
                        pendAddr_next = addrShifted;
                        pendData_next = '1;
                        state_next    = ST_HOLD;
                     end else begin
                        state_next = ST_HOLD;
                     end
                  end
               end
            end
            ST_READ: begin
               // the wire is not looked at here, so a clash cannot hurt
               if (skRise) begin // R5
                  if (bitCnt_reg == CNT_W'(DATA_W)) begin
                     dataOe_next = 1'b0;
                     state_next  = ST_HOLD;
                  end else begin
                     dataOut_next = shift_reg[DATA_W-1]; // R13
                     shift_next   = {shift_reg[DATA_W-2:0], 1'b0};
                     bitCnt_next  = bitCnt_reg + 1'b1;
                  end
               end
            end
            ST_WDATA: begin
               if (skRise) begin
                  shift_next  = {shift_reg[DATA_W-2:0], din};
                  bitCnt_next = bitCnt_reg + 1'b1;
                  if (bitCnt_reg == CNT_W'(DATA_W - 1)) begin
                     pend_next     = 1'b1;
                     pendAddr_next = addr_reg;
                     pendData_next = {shift_reg[DATA_W-2:0], din};
                     state_next    = ST_HOLD;
                  end
               end
            end
            default: begin
               state_next = ST_HOLD;
            end
         endcase

         // status shown while selected, cleared by a one on the wire
         if (armed_reg && !busy_reg && clearEdge && din) begin
            armed_next  = 1'b0; // R8
            dataOe_next = 1'b0;
         end else if (armed_reg) begin
            dataOe_next  = 1'b1; // R7
            dataOut_next = ~busy_reg; // R6
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= ST_IDLE;
         bitCnt_reg   <= '0;
         opcode_reg   <= OP_EXT;
         addr_reg     <= '0;
         shift_reg    <= '0;
         dataOut_reg  <= 1'b0;
         dataOe_reg   <= 1'b0;
         pend_reg     <= 1'b0;
         pendAddr_reg <= '0;
         pendData_reg <= '0;
         busy_reg     <= 1'b0;
         busyCnt_reg  <= '0;
         armed_reg    <= 1'b0;
      end else begin
         state_reg    <= state_next;
         bitCnt_reg   <= bitCnt_next;
         opcode_reg   <= opcode_next;
         addr_reg     <= addr_next;
         shift_reg    <= shift_next;
         dataOut_reg  <= dataOut_next;
         dataOe_reg   <= dataOe_next;
         pend_reg     <= pend_next;
         pendAddr_reg <= pendAddr_next;
         pendData_reg <= pendData_next;
         busy_reg     <= busy_next;
         busyCnt_reg  <= busyCnt_next;
         armed_reg    <= armed_next;
      end
   end

   // array starts erased
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_reg[i] <= '1;
         end
      end else if (memWe) begin
         mem_reg[pendAddr_reg] <= pendData_reg;
      end
   end

   assign link.devData   = dataOut_reg; // R1
   assign link.devDataOe = dataOe_reg;
   assign progBusy       = busy_reg;

endmodule // shared_io_eeprom_device

`default_nettype wire

// *** shared_io_eeprom_host.sv ***
/*
 Host end of the three-wire port: makes the serial clock by division,
 shifts instructions out, reads data back and polls programming status.
 Assumes the device end follows the shared-wire status sequence.
*/
`timescale 1ns/1ps
`default_nettype none

module shared_io_eeprom_host
   import eeprom_link_pkg::*;
#(
   parameter int ADDR_W     = DEF_ADDR_W,
   parameter int DATA_W     = DEF_DATA_W,
   parameter int HALF_TICKS = LINK_HALF_CYCLES
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // link to the device
   eeprom_link_if.host        link,
   // request
   input  wire logic          reqValid,
   output logic               reqReady,
   input  wire logic [1:0]    reqOp,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqData,
   // answer
   output logic               rspValid,
   output logic [DATA_W-1:0]  rspData
);

   localparam int CMD_BITS = 1 + OP_BITS + ADDR_W;
   localparam int FRAME_W  = CMD_BITS + DATA_W;
   localparam int CNT_W    = $clog2(FRAME_W + 2);
   localparam int DIV_W    = $clog2(HALF_TICKS + 1);

   typedef enum logic [3:0] {
      H_IDLE     = 4'h0,
      H_SHIFT    = 4'h1,
      H_RELEASE  = 4'h2,
      H_READ     = 4'h3,
      H_PROG_LOW = 4'h4,
      H_SETTLE   = 4'h5,
      H_POLL     = 4'h6,
      H_CLEAR    = 4'h7,
      H_END      = 4'h8,
      H_GAP      = 4'h9
   } host_state_t;

   logic              lineSync1_reg;
   logic              lineSync2_reg;
   logic [DIV_W-1:0]  div_reg;
   logic              tick;

   host_state_t       state_reg,    state_next;
   logic              cs_reg,       cs_next;
   logic              sk_reg,       sk_next;
   logic              dout_reg,     dout_next;
   logic              oe_reg,       oe_next;
   logic [FRAME_W-1:0] frame_reg,   frame_next;
   logic [CNT_W-1:0]  cnt_reg,      cnt_next;
   logic [1:0]        op_reg,       op_next;
   logic [DATA_W-1:0] rd_reg,       rd_next;
   logic              rspValid_reg, rspValid_next;

   // data wire comes from the other party's timing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lineSync1_reg <= RESET_LINE;
         lineSync2_reg <= RESET_LINE;
         div_reg       <= '0;
      end else begin
         lineSync1_reg <= link.hostDataIn;
         lineSync2_reg <= lineSync1_reg;
         div_reg       <= tick ? '0 : div_reg + 1'b1;
      end
   end

   assign tick     = (div_reg == DIV_W'(HALF_TICKS - 1));
   assign reqReady = (state_reg == H_IDLE);

   always_comb begin
      state_next    = state_reg;
      cs_next       = cs_reg;
      sk_next       = sk_reg;
      dout_next     = dout_reg;
      oe_next       = oe_reg;
      frame_next    = frame_reg;
      cnt_next      = cnt_reg;
      op_next       = op_reg;
      rd_next       = rd_reg;
      rspValid_next = 1'b0;

      case (state_reg)
         H_IDLE: begin
            if (reqValid) begin
               op_next    = reqOp;
               frame_next = {1'b1, reqOp, reqAddr,
                             (reqOp == OP_WRITE) ? reqData : DATA_W'(0)};
               cnt_next   = (reqOp == OP_WRITE) ? CNT_W'(FRAME_W)
                                                : CNT_W'(CMD_BITS);
               cs_next    = 1'b1;
               sk_next    = 1'b0;
               dout_next  = 1'b1;
               oe_next    = 1'b1;
               state_next = H_SHIFT;
            end
         end
         H_SHIFT: begin
            if (tick && !sk_reg) begin
               sk_next  = 1'b1;
               cnt_next = cnt_reg - 1'b1;
               if (cnt_reg == CNT_W'(1) && op_reg == OP_READ) begin
                  state_next = H_RELEASE;
               end
            end else if (tick) begin
               sk_next    = 1'b0;
               frame_next = {frame_reg[FRAME_W-2:0], 1'b0};
               dout_next  = frame_reg[FRAME_W-2];
               if (cnt_reg == '0) begin
                  oe_next    = 1'b0;
                  cs_next    = 1'b0;
                  state_next = (op_reg == OP_EXT) ? H_END : H_PROG_LOW;
               end
            end
         end
         H_RELEASE: begin
            // let go of the wire before the dummy zero arrives
            oe_next    = 1'b0; // R4
            cnt_next   = CNT_W'(DATA_W + 1);
            state_next = H_READ;
         end
         H_READ: begin
            if (tick && sk_reg) begin
               sk_next = 1'b0;
               if (cnt_reg == '0) begin
                  state_next = H_END;
               end
            end else if (tick) begin
               // first sample is the dummy zero and falls out the top
               rd_next  = {rd_reg[DATA_W-2:0], lineSync2_reg};
               sk_next  = 1'b1;
               cnt_next = cnt_reg - 1'b1;
            end
         end
         H_PROG_LOW: begin
            if (tick) begin
               cs_next    = 1'b1; // R7
               cnt_next   = CNT_W'(STATUS_SETTLE_TICKS);
               state_next = H_SETTLE;
            end
         end
         H_SETTLE: begin
            if (tick) begin
               cnt_next = cnt_reg - 1'b1;
               if (cnt_reg == CNT_W'(1)) begin
                  state_next = H_POLL;
               end
            end
         end
         H_POLL: begin
            // clock stays stopped until the ready one has been seen
            if (tick && lineSync2_reg) begin // R9
               sk_next    = 1'b1; // R10
               state_next = H_CLEAR;
            end
         end
         H_CLEAR: begin
            if (tick) begin
               sk_next    = 1'b0;
               state_next = H_END;
            end
         end
         H_END: begin
            cs_next       = 1'b0; // R11
            sk_next       = 1'b0;
            oe_next       = 1'b0;
            rspValid_next = 1'b1;
            cnt_next      = CNT_W'(GAP_TICKS);
            state_next    = H_GAP;
         end
         H_GAP: begin
            if (tick) begin
               cnt_next = cnt_reg - 1'b1;
               if (cnt_reg == CNT_W'(1)) begin
                  state_next = H_IDLE;
               end
            end
         end
         default: begin
            state_next = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg    <= H_IDLE;
         cs_reg       <= RESET_SELECT;
         sk_reg       <= RESET_CLOCK;
         dout_reg     <= 1'b0;
         oe_reg       <= 1'b0;
         frame_reg    <= '0;
         cnt_reg      <= '0;
         op_reg       <= OP_EXT;
         rd_reg       <= '0;
         rspValid_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         cs_reg       <= cs_next;
         sk_reg       <= sk_next;
         dout_reg     <= dout_next;
         oe_reg       <= oe_next;
         frame_reg    <= frame_next;
         cnt_reg      <= cnt_next;
         op_reg       <= op_next;
         rd_reg       <= rd_next;
         rspValid_reg <= rspValid_next;
      end
   end

   assign link.chipSelect    = cs_reg;
   assign link.serialClockIn = sk_reg;
   assign link.hostData      = dout_reg;
   assign link.hostDataOe    = oe_reg;
   assign rspValid           = rspValid_reg;
   assign rspData            = rd_reg;

endmodule // shared_io_eeprom_host

`default_nettype wire

// *** eeprom_link_sva.sv ***
/*
 Checker for the shared-wire EEPROM link, all on core_clk.
 Assumes the signals of the first link instance as plain inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module eeprom_link_sva
   import eeprom_link_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // link
   input wire logic chipSelect,
   input wire logic serialClockIn,
   input wire logic hostDataOe,
   input wire logic devData,
   input wire logic devDataOe,
   input wire logic lineLevel
);
   logic       clkDly_reg,  clkDly_next;
   logic [7:0] idleCnt_reg, idleCnt_next;
   logic [1:0] riseCnt_reg, riseCnt_next;
   logic [2:0] cmd_reg,     cmd_next;
   logic       riseSeen;

   // a long idle clock marks the status phase, a running one read data
   always_comb begin
      riseSeen     = serialClockIn & ~clkDly_reg;
      clkDly_next  = serialClockIn;
      idleCnt_next = (serialClockIn != clkDly_reg) ? 8'h00
                   : idleCnt_reg + {7'h00, idleCnt_reg != 8'hff};
      riseCnt_next = !chipSelect ? 2'h0
                   : riseCnt_reg + {1'b0, riseSeen & (riseCnt_reg != 2'h3)};
      cmd_next     = (riseSeen && riseCnt_reg != 2'h3)
                   ? {cmd_reg[1:0], lineLevel} : cmd_reg;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clkDly_reg  <= 1'b0;
         idleCnt_reg <= 8'h00;
         riseCnt_reg <= 2'h0;
         cmd_reg     <= 3'h0;
      end else begin
         clkDly_reg  <= clkDly_next;
         idleCnt_reg <= idleCnt_next;
         riseCnt_reg <= riseCnt_next;
         cmd_reg     <= cmd_next;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   drive_exclusive_a: assert property (hostDataOe |-> !devDataOe)
      else $error("both ends drive the data wire");
   dummy_zero_a: assert property ($fell(hostDataOe) && chipSelect
      && cmd_reg == {1'b1, OP_READ} |-> ##[1:4] (devDataOe && !devData))
      else $error("no dummy zero after the read address");
   deselect_quiet_a: assert property (!chipSelect
      && !$past(chipSelect, 4) |-> !devDataOe)
      else $error("device drives while deselected");
   status_hold_a: assert property (devDataOe && !devData && chipSelect
      && idleCnt_reg >= 8'd10 |=> devDataOe || !chipSelect)
      else $error("busy status dropped while selected");
   status_order_a: assert property (devDataOe && devData && chipSelect
      && idleCnt_reg >= 8'd10 |=> !(devDataOe && !devData))
      else $error("ready status went back to busy");
   busy_clock_stop_a: assert property (devDataOe && !devData
      && idleCnt_reg >= 8'd10 |=> $stable(serialClockIn))
      else $error("clock moved during busy status");
   ready_pulse_a: assert property ($rose(devData) && devDataOe
      && idleCnt_reg >= 8'd10 |-> ##[1:60] $rose(serialClockIn))
      else $error("no clearing pulse after ready status");
   status_clear_a: assert property ($rose(serialClockIn) && devDataOe
      && devData && idleCnt_reg >= 8'd10 |-> ##[1:8] !devDataOe)
      else $error("ready status not released after clock pulse");

   cover property ($fell(hostDataOe) && cmd_reg == {1'b1, OP_READ});
   cover property (devDataOe && !devData && idleCnt_reg >= 8'd10);
   cover property (devDataOe && devData && idleCnt_reg >= 8'd10);
endmodule // eeprom_link_sva

`default_nettype wire

// *** shared_io_serial_eeprom_port_bench.sv ***
/*
 Bench for the shared-wire EEPROM port: two host/device pairs in
 lockstep, the second on separate data wires, clearing status on the
 falling clock edge.
 Assumes the package values and a 100 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module shared_io_serial_eeprom_port_bench
   import eeprom_link_pkg::*;
;
   // short programming keeps the run brief
   localparam int PROG = 20;

   logic       core_clk  = 1'b0;
   logic       rst_n     = 1'b0;
   logic       reqValid  = 1'b0;
   logic [1:0] reqOp     = 2'h0;
   logic [5:0] reqAddr   = 6'h00;
   logic [7:0] reqData   = 8'h00;
   logic       reqReady, reqReadyF, rspValid, rspValidF;
   logic       progBusy, progBusyF;
   logic [7:0] rspData,  rspDataF;
   bit         busySeen;
   int         n_fail    = 0;
   int         cmp_count = 0;

   always #5 core_clk = ~core_clk;

   eeprom_link_if eeprom_link_if_i ();
   eeprom_link_if #(.SHARED_IO(1'b0)) eeprom_link_if_fall_i ();

   shared_io_eeprom_device #(.PROG_CYCLES(PROG)) shared_io_eeprom_device_i (
      .core_clk(core_clk), .rst_n(rst_n), .link(eeprom_link_if_i),
      .progBusy(progBusy));
   shared_io_eeprom_host shared_io_eeprom_host_i (
      .core_clk(core_clk), .rst_n(rst_n), .link(eeprom_link_if_i),
      .reqValid(reqValid), .reqReady(reqReady), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
      .rspData(rspData));
   shared_io_eeprom_device #(.PROG_CYCLES(PROG), .CLEAR_ON_FALL(1'b1))
      shared_io_eeprom_device_fall_i (
      .core_clk(core_clk), .rst_n(rst_n), .link(eeprom_link_if_fall_i),
      .progBusy(progBusyF));
   shared_io_eeprom_host shared_io_eeprom_host_fall_i (
      .core_clk(core_clk), .rst_n(rst_n), .link(eeprom_link_if_fall_i),
      .reqValid(reqValid), .reqReady(reqReadyF), .reqOp(reqOp),
      .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValidF),
      .rspData(rspDataF));

   eeprom_link_sva eeprom_link_sva_i (
      .core_clk     (core_clk),
      .rst_n        (rst_n),
      .chipSelect   (eeprom_link_if_i.chipSelect),
      .serialClockIn(eeprom_link_if_i.serialClockIn),
      .hostDataOe   (eeprom_link_if_i.hostDataOe),
      .devData      (eeprom_link_if_i.devData),
      .devDataOe    (eeprom_link_if_i.devDataOe),
      .lineLevel    (eeprom_link_if_i.lineLevel));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // both hosts take the request on the same edge, then both must answer
   task automatic run_op(input logic [1:0] op, input logic [5:0] addr,
                         input logic [7:0] data);
      int  n;
      bit  gotA;
      bit  gotB;
      gotA = 0;
      gotB = 0;
      busySeen = 0;
      @(posedge core_clk);
      reqOp    <= op;
      reqAddr  <= addr;
      reqData  <= data;
      reqValid <= 1'b1;
      #1;
      for (n = 0; n < 300 && !(reqReady === 1'b1 && reqReadyF === 1'b1);
           n++) begin
         @(posedge core_clk);
         #1;
      end
      if (n == 300) begin
         n_fail++;
         test_done();
      end
      @(posedge core_clk);
      reqValid <= 1'b0;
      for (n = 0; n < 3000 && !(gotA && gotB); n++) begin
         @(posedge core_clk);
         #1;
         gotA = gotA | (rspValid === 1'b1);
         gotB = gotB | (rspValidF === 1'b1);
         busySeen = busySeen | (progBusy === 1'b1 && progBusyF === 1'b1);
      end
      if (!(gotA && gotB)) begin
         n_fail++;
         test_done();
      end
      check({progBusy, eeprom_link_if_i.devDataOe}, 2'h0);
   endtask

   task automatic read_check(input logic [5:0] addr, input logic [7:0] exp);
      run_op(OP_READ, addr, 8'h00);
      check(rspData, exp);
      check(rspDataF, exp);
   endtask

   task automatic write_check(input logic [1:0] op, input logic [5:0] addr,
                              input logic [7:0] data);
      run_op(op, addr, data);
      check(busySeen, 1'b1);
   endtask

   // fresh array reads all ones at both address extremes
   task automatic reset_reads();
      read_check(6'h00, 8'hff);
      read_check(6'h3f, 8'hff);
   endtask

   // write then read straight back; odd address ends on a one
   task automatic write_reads();
      logic [5:0] adr [3] = '{6'h3f, 6'h00, 6'h15};
      logic [7:0] val [3] = '{8'h5a, 8'ha5, 8'h81};
      for (int i = 0; i < 3; i++) begin
         write_check(OP_WRITE, adr[i], val[i]);
         read_check(adr[i], val[i]);
      end
      read_check(6'h3f, 8'h5a);
   endtask

   task automatic erase_read();
      write_check(OP_ERASE, 6'h15, 8'h00);
      read_check(6'h15, 8'hff);
      read_check(6'h00, 8'ha5);
   endtask

   // ext op leaves the last read data untouched
   task automatic ext_idle();
      run_op(OP_EXT, 6'h2a, 8'h00);
      check(busySeen, 1'b0);
      check(rspData, 8'ha5);
   endtask

   initial begin
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      reset_reads();
      write_reads();
      erase_read();
      ext_idle();
      test_done();
   end
endmodule // shared_io_serial_eeprom_port_bench

`default_nettype wire
